// >>> rx_serdes_interrupt_flags.sv
/*
  Receive serializer interrupt flags: bit assembly for two receive channels,
  end-of-frame detection, receive data registers, interrupt enable and
  status registers, and the interrupt request output.
  Assumes the serial control port is decoded outside into one-cycle read
  and write strobes with address and data, and that each receiver presents
  one bit-time tick with a correlation-valid flag and the bit value.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_serdes_interrupt_flags import rx_serdes_pkg::*; #(
  parameter int unsigned FIFO_DEPTH = RXA_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire rx_bit_t [NUM_CH-1:0] rx_bit,
  input wire logic rx_flow_hold,
  output logic rxa_fifo_ready,
  output logic irq
);

  generate
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
      $error("rx_serdes_interrupt_flags: FIFO_DEPTH must be a power of two");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] shreg;
    logic [3:0] nbits;
    logic started;
    logic [3:0] idle;
  } assembler_t;

  typedef struct packed {
    assembler_t [NUM_CH-1:0] asmb;
    logic [NUM_CH-1:0][7:0] data;
    logic [NUM_CH-1:0] dfull;
    logic [7:0] stat;
    logic [7:0] en;
    logic [7:0] ctl;
    logic [7:0] rdata;
    // Which kind of fault is pending, per channel; the status bit merges them.
    logic [NUM_CH-1:0] under_pend;
    logic [NUM_CH-1:0] over_pend;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [NUM_CH-1:0] byte_ev;
  logic [NUM_CH-1:0] eof_ev;
  rx_word_t [NUM_CH-1:0] word;
  logic [NUM_CH-1:0] ld;
  rx_word_t [NUM_CH-1:0] ld_word;
  logic [2:0] eof_len;
  logic fifo_out_valid;
  logic fifo_out_ready;
  rx_word_t fifo_out_data;
  logic stat_rd;
  logic [7:0] fault_mask;
  logic [7:0] valid_mask;
  logic [NUM_CH-1:0] flow_irq;

  assign eof_len = st_ff.ctl[EOF_LEN_MSB:EOF_LEN_LSB];
  assign stat_rd = reg_req.rd && (reg_req.addr == ADDR_IRQ_STATUS);

  // ----------------------------------------------------------------------
  // Channel A byte buffer
  // ----------------------------------------------------------------------
  // With the hold input low the buffer drains every cycle, so the data
  // register can be overwritten; with it high, bytes wait until the host
  // has emptied the register and the buffer absorbs the burst instead.
  assign fifo_out_ready = !rx_flow_hold || !st_ff.dfull[0];

  rx_byte_fifo #(
    .WIDTH($bits(rx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rxa_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(byte_ev[0]),
    .in_ready(rxa_fifo_ready),
    .in_data(word[0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign ld[0] = fifo_out_valid && fifo_out_ready;
  assign ld_word[0] = fifo_out_data;
  assign ld[1] = byte_ev[1];
  assign ld_word[1] = word[1];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] shifted;
    logic [3:0] idle_inc;
    logic [7:0] clr;
    logic [7:0] setb;
    int unsigned base;
    nxt_st = st_ff;
    byte_ev = '0;
    eof_ev = '0;
    word = '0;
    clr = 8'h00;
    setb = 8'h00;
    shifted = 8'h00;
    idle_inc = 4'h0;
    base = 0;

    // Bit assembly and end-of-frame detection.
    for (int c = 0; c < NUM_CH; c++) begin
      shifted = {st_ff.asmb[c].shreg[6:0], rx_bit[c].data};
      idle_inc = (st_ff.asmb[c].idle == IDLE_MAX) ? IDLE_MAX : st_ff.asmb[c].idle + 4'h1;
      if (rx_bit[c].tick) begin
        if (rx_bit[c].valid) begin
          nxt_st.asmb[c].shreg = shifted;
          nxt_st.asmb[c].started = 1'b1;
          nxt_st.asmb[c].idle = 4'h0;
          if (st_ff.asmb[c].nbits == LAST_BIT) begin
            byte_ev[c] = 1'b1;
            word[c].data = shifted;
            word[c].all_valid = 1'b1;
            nxt_st.asmb[c].nbits = 4'h0;
            // Start the next byte from zero so a short tail at end of frame
            // is flushed right-aligned instead of mixed with older bits.
            nxt_st.asmb[c].shreg = 8'h00;
          end else begin
            nxt_st.asmb[c].nbits = st_ff.asmb[c].nbits + 4'h1;
          end
        end else if (st_ff.asmb[c].started) begin
          nxt_st.asmb[c].idle = idle_inc;
          if (idle_inc > {1'b0, eof_len}) begin
            eof_ev[c] = 1'b1;
            // A partial byte is flushed at end of frame, marked not valid.
            byte_ev[c] = (st_ff.asmb[c].nbits != 4'h0);
            word[c].data = st_ff.asmb[c].shreg;
            word[c].all_valid = 1'b0;
            nxt_st.asmb[c] = '0;
          end
        end
      end
    end

    // Register writes.
    if (reg_req.wr) begin
      if (reg_req.addr == ADDR_SERDES_CTRL) begin
        nxt_st.ctl = reg_req.wdata;
      end
      if (reg_req.addr == ADDR_IRQ_ENABLE) begin
        nxt_st.en = reg_req.wdata;
      end
    end

    // Register reads and their side effects.
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_SERDES_CTRL: nxt_st.rdata = st_ff.ctl;
        ADDR_IRQ_ENABLE: nxt_st.rdata = st_ff.en;
        ADDR_IRQ_STATUS: begin
          nxt_st.rdata = st_ff.stat;
          clr = STAT_READ_CLEAR;
          nxt_st.under_pend = '0;
          nxt_st.over_pend = '0;
        end
        ADDR_RX_DATA_A, ADDR_RX_DATA_B: begin
          base = (reg_req.addr == ADDR_RX_DATA_A) ? 0 : 1;
          nxt_st.rdata = st_ff.data[base];
          if (st_ff.dfull[base]) begin
            nxt_st.dfull[base] = 1'b0;
          end else begin
            setb[base * CH_STRIDE + STAT_FAULT] = 1'b1;
            nxt_st.under_pend[base] = 1'b1;
          end
        end
        default: nxt_st.rdata = UNMAPPED_READ;
      endcase
    end

    // Loads into the data registers; a new byte on a full register counts
    // as an overwrite, and a byte lost at a full buffer does too.
    for (int c = 0; c < NUM_CH; c++) begin
      base = c * CH_STRIDE;
      if (eof_ev[c]) begin
        setb[base + STAT_EOF] = 1'b1;
      end
      if (ld[c]) begin
        if (nxt_st.dfull[c]) begin
          setb[base + STAT_FAULT] = 1'b1;
          nxt_st.over_pend[c] = 1'b1;
        end
        nxt_st.data[c] = ld_word[c].data;
        nxt_st.dfull[c] = 1'b1;
        setb[base + STAT_FULL] = 1'b1;
      end
    end
    if (byte_ev[0] && !rxa_fifo_ready) begin
      setb[STAT_FAULT] = 1'b1;
      nxt_st.over_pend[0] = 1'b1;
    end

    // Sets win over the read-clear so no event is lost.
    nxt_st.stat = (st_ff.stat & ~clr) | setb;
    for (int c = 0; c < NUM_CH; c++) begin
      if (ld[c]) begin
        nxt_st.stat[c * CH_STRIDE + STAT_VALID] = ld_word[c].all_valid;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.stat <= RST_IRQ_STATUS;
      st_ff.en <= RST_IRQ_ENABLE;
      st_ff.ctl <= RST_SERDES_CTRL;
      st_ff.data <= {NUM_CH{RST_RX_DATA}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st_ff.rdata;

  // The fault status bit merges empty reads and overwrites, yet each has its
  // own enable, so the request takes the faults from the hidden pending bits
  // and masks the fault bits out of the status term. The capable set keeps
  // the valid bits out of the request.
  always_comb begin
    fault_mask = 8'h00;
    valid_mask = 8'h00;
    flow_irq = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      fault_mask[c * CH_STRIDE + STAT_FAULT] = 1'b1;
      valid_mask[c * CH_STRIDE + STAT_VALID] = 1'b1;
      flow_irq[c] = (st_ff.under_pend[c] && st_ff.en[c * CH_STRIDE + EN_UNDER])
        || (st_ff.over_pend[c] && st_ff.en[c * CH_STRIDE + EN_OVER]);
    end
  end
  assign irq = |(st_ff.stat & st_ff.en & IRQ_CAPABLE & ~fault_mask) || (|flow_irq);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_data_a_empty;
    reg_req.rd && reg_req.addr == ADDR_RX_DATA_A && !st_ff.dfull[0];
  endsequence

  sequence s_status_read_quiet;
    stat_rd && eof_ev == '0 && !ld[0] && !ld[1] && !(reg_req.wr) && !byte_ev[0];
  endsequence

  sequence s_first_invalid_len0;
    st_ff.asmb[1].started && rx_bit[1].tick && !rx_bit[1].valid && eof_len == 3'h0;
  endsequence

  a_underflow_flag: assert property (s_read_data_a_empty |=> st_ff.stat[STAT_FAULT])
    else $error("empty read of data A did not set the fault flag");

  a_overflow_flag: assert property (ld[0] && st_ff.dfull[0]
    && !(reg_req.rd && reg_req.addr == ADDR_RX_DATA_A) |=> st_ff.stat[STAT_FAULT])
    else $error("overwrite of data A did not set the fault flag");

  // A byte dropped at a full buffer counts as an overwrite as well.
  a_fifo_loss: assert property (byte_ev[0] && !rxa_fifo_ready
    |=> st_ff.stat[STAT_FAULT] && st_ff.over_pend[0])
    else $error("byte lost at the full buffer did not set the fault flag");

  a_underflow_b: assert property (reg_req.rd && reg_req.addr == ADDR_RX_DATA_B && !st_ff.dfull[1]
    |=> st_ff.stat[CH_STRIDE + STAT_FAULT] && st_ff.under_pend[1])
    else $error("empty read of data B did not set the fault flag");

  a_eof_len_zero: assert property (s_first_invalid_len0 |=> st_ff.stat[CH_STRIDE + STAT_EOF]
    && !st_ff.asmb[1].started)
    else $error("zero end-of-frame length did not end the frame");

  a_eof_after_idle: assert property ($rose(st_ff.stat[STAT_EOF]) |->
    $past(st_ff.asmb[0].started) && $past(st_ff.asmb[0].idle) >= {1'b0, $past(eof_len)})
    else $error("end of frame raised without enough idle bits after a valid bit");

  a_status_clear: assert property (s_status_read_quiet |=>
    st_ff.stat[STAT_EOF] == 1'b0 && st_ff.stat[STAT_FAULT] == 1'b0 && st_ff.stat[CH_STRIDE + STAT_EOF] == 1'b0
    && st_ff.stat[CH_STRIDE + STAT_FAULT] == 1'b0)
    else $error("status read did not clear pending flags");

  a_load_a_full: assert property (ld[0] |=> st_ff.stat[STAT_FULL] && st_ff.dfull[0]
    && st_ff.data[0] == $past(ld_word[0].data))
    else $error("load of data A did not raise data-arrived");

  a_load_b_valid: assert property (ld[1] |=> st_ff.stat[CH_STRIDE + STAT_FULL]
    && st_ff.stat[CH_STRIDE + STAT_VALID] == $past(ld_word[1].all_valid))
    else $error("load of data B set wrong full or valid flag");

  // Built from the valid positions, not the capable set, so a capable set
  // that wrongly held a valid bit would be caught here.
  a_valid_no_irq: assert property ((st_ff.stat & st_ff.en & ~valid_mask) == 8'h00
    && st_ff.under_pend == '0 && st_ff.over_pend == '0 |-> !irq)
    else $error("interrupt raised with no enabled capable flag");

  a_enable_gates: assert property (s_read_data_a_empty ##1 st_ff.en[EN_UNDER] |-> irq)
    else $error("enabled empty-read fault did not raise the interrupt");

  a_overwrite_irq: assert property (ld[0] && st_ff.dfull[0]
    && !(reg_req.rd && reg_req.addr == ADDR_RX_DATA_A) ##1 st_ff.en[EN_OVER] |-> irq)
    else $error("enabled overwrite fault did not raise the interrupt");

  a_eof_full_irq: assert property ((st_ff.stat[STAT_EOF] && st_ff.en[1])
    || (st_ff.stat[STAT_FULL] && st_ff.en[0]) |-> irq)
    else $error("enabled end-of-frame or data-arrived flag did not interrupt");

  a_reset_zero: assert property ($rose(rstn) |-> st_ff.stat == RST_IRQ_STATUS)
    else $error("status register not zero after reset");

endmodule
`default_nettype wire

// >>> rx_serdes_pkg.sv
/*
  Shared constants and carrier types for the receive serializer interrupt
  flags block and its byte FIFO.
  Assumes the register port carries 8-bit addresses and 8-bit data, as
  decoded from the serial control port outside this block.
*/
package rx_serdes_pkg;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_SERDES_CTRL = 8'h06;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h07;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA_A = 8'h09;
  localparam logic [7:0] ADDR_RX_DATA_B = 8'h0b;
  localparam logic [7:0] RST_SERDES_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CH_STRIDE = 4;
  localparam int unsigned STAT_FULL = 0;
  localparam int unsigned STAT_EOF = 1;
  localparam int unsigned STAT_FAULT = 2;
  localparam int unsigned STAT_VALID = 3;
  localparam int unsigned EN_UNDER = 3;
  localparam int unsigned EN_OVER = 2;
  localparam int unsigned EOF_LEN_MSB = 2;
  localparam int unsigned EOF_LEN_LSB = 0;
  localparam logic [7:0] IRQ_CAPABLE = 8'h77;
  localparam logic [7:0] STAT_READ_CLEAR = 8'h77;

  // ----------------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] IDLE_MAX = 4'hf;
  localparam int unsigned RXA_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic tick;
    logic valid;
    logic data;
  } rx_bit_t;

  typedef struct packed {
    logic all_valid;
    logic [7:0] data;
  } rx_word_t;

endpackage

// >>> rx_byte_fifo.sv
/*
  Synchronous FIFO for received bytes, valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset; DEPTH is a power
  of two so the wrap bit of each pointer tells full from empty.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_byte_fifo import rx_serdes_pkg::*; #(
  parameter int unsigned WIDTH = $bits(rx_word_t),
  parameter int unsigned DEPTH = RXA_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("rx_byte_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_t;

  fifo_state_t st_ff;
  fifo_state_t nxt_st;
  logic full;
  logic empty;

  assign full = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign empty = (st_ff.wp == st_ff.rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_ff.mem[st_ff.rp[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// >>> rx_host_model.sv
/*
  Far-side model: the host's register strobes and the two receiver bit
  streams, offered as tasks that the testbench calls.
  Assumes the block samples its inputs on the rising edge of sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_host_model import rx_serdes_pkg::*; (
  input wire logic sys_clk,
  output reg_req_t reg_req,
  output rx_bit_t [NUM_CH-1:0] rx_bit,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  initial begin
    reg_req = '0;
    rx_bit = '0;
  end

  // Released address and data show the inverse so stale values cannot pass.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask

  // ----------------------------------------------------------------------
  // Receiver bit streams
  // ----------------------------------------------------------------------
  task automatic send_bit(input int ch, input logic v, input logic d);
    @(posedge sys_clk);
    rx_bit[ch] <= '{tick: 1'b1, valid: v, data: d};
    @(posedge sys_clk);
    rx_bit[ch] <= '{tick: 1'b0, valid: ~v, data: ~d};
  endtask

  // Bytes go out most significant bit first; a short pause lets the load land.
  task automatic send_byte(input int ch, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_bit(ch, 1'b1, b[i]);
    end
    repeat (3) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> rx_serdes_interrupt_flags_test.sv
/*
  Self-checking testbench for the receive interrupt flags block.
  Assumes the host model in rx_host_model.sv and a FIFO depth of 2.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_serdes_interrupt_flags_test import rx_serdes_pkg::*;;
  logic sys_clk;
  logic rstn;
  logic rx_flow_hold;
  logic rxa_fifo_ready;
  logic irq;
  logic [7:0] reg_rdata;
  logic [7:0] junk;
  reg_req_t reg_req;
  rx_bit_t [NUM_CH-1:0] rx_bit;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  rx_serdes_interrupt_flags #(.FIFO_DEPTH(2)) uut (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rx_bit(rx_bit), .rx_flow_hold(rx_flow_hold), .rxa_fifo_ready(rxa_fifo_ready),
    .irq(irq));
  rx_host_model host (.sys_clk(sys_clk), .reg_req(reg_req), .rx_bit(rx_bit), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] addrs [4] = '{ADDR_SERDES_CTRL, ADDR_IRQ_ENABLE, ADDR_IRQ_STATUS, 8'h20};
    foreach (addrs[i]) begin
      rd_chk(addrs[i], 8'h00);
    end
    chk_bit(irq, 1'b0);
    chk_bit(rxa_fifo_ready, 1'b1);
  endtask

  task automatic test_chan_b();
    host.wr_reg(ADDR_SERDES_CTRL, 8'h00);
    host.send_byte(1, 8'ha5);
    rd_chk(ADDR_IRQ_STATUS, 8'h90);
    host.wr_reg(ADDR_IRQ_ENABLE, 8'hff);
    settle(1);
    chk_bit(irq, 1'b0);
    rd_chk(ADDR_RX_DATA_B, 8'ha5);
    host.send_bit(1, 1'b1, 1'b1);
    host.send_bit(1, 1'b1, 1'b0);
    host.send_bit(1, 1'b1, 1'b1);
    host.send_bit(1, 1'b0, 1'b0);
    settle(3);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 8'h30);
    rd_chk(ADDR_RX_DATA_B, 8'h05);
    rd_chk(ADDR_RX_DATA_B, 8'h05);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 8'h40);
  endtask

  // Two idle bits must not end the frame at length 2; the third must.
  task automatic test_eof_a();
    host.wr_reg(ADDR_SERDES_CTRL, 8'h02);
    host.wr_reg(ADDR_IRQ_ENABLE, 8'h02);
    host.send_bit(0, 1'b1, 1'b1);
    host.send_bit(0, 1'b0, 1'b0);
    host.send_bit(0, 1'b0, 1'b0);
    settle(3);
    chk_bit(irq, 1'b0);
    host.send_bit(0, 1'b0, 1'b0);
    settle(3);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 8'h03);
    settle(1);
    chk_bit(irq, 1'b0);
  endtask

  task automatic test_empty_a();
    rd_chk(ADDR_RX_DATA_A, 8'h01);
    host.wr_reg(ADDR_IRQ_ENABLE, 8'h08);
    host.rd_reg(ADDR_RX_DATA_A, junk);
    settle(2);
    chk_bit(irq, 1'b1);
    host.wr_reg(ADDR_IRQ_ENABLE, 8'h00);
    settle(1);
    chk_bit(irq, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 8'h04);
  endtask

  // Holding data A lets the FIFO fill; releasing the hold forces an overwrite.
  task automatic test_fifo_a();
    @(posedge sys_clk);
    rx_flow_hold <= 1'b1;
    host.wr_reg(ADDR_IRQ_ENABLE, 8'h05);
    host.send_byte(0, 8'h3c);
    settle(1);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 8'h09);
    host.send_byte(0, 8'hc3);
    host.send_byte(0, 8'h5a);
    settle(1);
    chk_bit(rxa_fifo_ready, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 8'h08);
    host.send_byte(0, 8'h99);
    rd_chk(ADDR_IRQ_STATUS, 8'h0c);
    rd_chk(ADDR_RX_DATA_A, 8'h3c);
    settle(3);
    rd_chk(ADDR_IRQ_STATUS, 8'h09);
    @(posedge sys_clk);
    rx_flow_hold <= 1'b0;
    settle(4);
    chk_bit(irq, 1'b1);
    rd_chk(ADDR_IRQ_STATUS, 8'h0d);
    rd_chk(ADDR_RX_DATA_A, 8'h5a);
    chk_bit(rxa_fifo_ready, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Clock, run control and verdict
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // The whole run needs under two thousand cycles; the ceiling leaves room.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    rx_flow_hold = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset();
    test_chan_b();
    test_eof_a();
    test_empty_a();
    test_fifo_a();
    give_verdict();
  end
endmodule
`default_nettype wire
